// *** src/fpe_top.sv ***
`timescale 1ns/10ps
// Flash protection and programming-mode entry. The parallel port and
// the flash array share core_clk; mode pins and the serial link
// are synchronised here.
module fpe_top
    import fpe_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       mode_select_pin,
    input  wire logic                       reset_control_input,
    input  wire logic                       chip_enable_pin,
    input  wire logic                       serial_shift_clock_pin,
    input  wire logic                       serial_receive_pin,
    input  wire logic                       serial_transmit_pin_i,
    output logic                            serial_transmit_pin_o,
    output logic                            serial_transmit_pin_oe,
    output logic                            busy_pin,
    input  wire fpe_freq_s                  pp_req,
    input  wire logic                       pp_tester,
    output logic [7:0]                      pp_rdata,
    output logic                            pp_done,
    output logic                            pp_refused,
    input  wire logic [2:0]                 reg_addr,
    input  wire logic [15:0]                reg_wdata,
    input  wire logic                       reg_we,
    input  wire logic                       reg_re,
    output logic [15:0]                     reg_rdata,
    output fpe_freq_s                       fl_req,
    input  wire logic [7:0]                 fl_rdata,
    input  wire logic [7:0]                 array_prot_byte,
    input  wire logic [ID_BYTES-1:0][7:0]   array_id,
    input  wire logic                       array_blank
);
    logic [5:0]  pin_raw;
    logic [5:0]  sync1_q;
    logic [5:0]  sync2_q;
    fpe_pins_s   pins;
    logic        captured_q;
    fpe_mode_e   mode_q;
    logic        serial;
    logic        parallel;
    logic        prot_on;
    logic        level2;
    logic        pp_block;
    logic        pp_boot;
    logic [1:0]  ctrl_q;
    logic [15:0] faddr_q;
    logic [7:0]  fdata_q;
    logic        cmd_wr;
    logic        cpu_boot;
    logic        cpu_ok;
    logic        cpu_bad;
    fpe_op_e     cpu_op;
    logic        rd_pend_q;
    logic        rd_cpu_q;
    logic        refused_q;
    fpe_ser_e    ser_q;
    logic [2:0]  id_idx_q;
    logic        id_bad_q;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic [7:0]  rx_hold_q;
    logic        rx_full_q;
    logic        rx_pop;
    logic        tx_busy;
    logic        txd;
    logic [15:0] stat_word;

    // Two-flop synchronisers, left without reset on purpose so
    // that they track the pins while reset is held, as the
    // mode capture at release needs.
    assign pin_raw = {mode_select_pin, reset_control_input, chip_enable_pin,
                      serial_shift_clock_pin, serial_transmit_pin_i, serial_receive_pin};
    for (genvar i = 0; i < 6; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            sync1_q[i] <= pin_raw[i];
            sync2_q[i] <= sync1_q[i];
        end
    end
    assign pins = fpe_pins_s'(sync2_q);

    // Mode selection happens once, at the first edge after reset release.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            captured_q <= 1'b0;
            mode_q     <= MODE_NORMAL;
        end else if (!captured_q) begin
            captured_q <= 1'b1; // RULE_19
            if (!pins.mode_sel) begin
                mode_q <= MODE_NORMAL; // RULE_12
            end else if (!pins.rst_ctl && pins.ce && !pins.sclk && pins.txd) begin
                mode_q <= MODE_SERIAL; // RULE_11 RULE_18
            end else begin
                mode_q <= MODE_PARALLEL;
            end
        end
    end
    assign serial   = (mode_q == MODE_SERIAL);
    assign parallel = (mode_q == MODE_PARALLEL);

    // Protection decode from the stored control byte. Release bits of 00
    // override the level bits, and level 2 wins when both levels are set.
    assign prot_on = ~(array_prot_byte[PROT_L1_BIT] & array_prot_byte[PROT_L2_BIT]) // RULE_01
                   & (array_prot_byte[REL_HI_BIT] | array_prot_byte[REL_LO_BIT]); // RULE_04
    assign level2  = prot_on & ~array_prot_byte[PROT_L2_BIT]; // RULE_03

    // Parallel gating: only a tester read at level 1 gets through while
    // protection is on; every modification is refused, release bits too.
    assign pp_block = prot_on & ((pp_req.op != OP_READ) | ~pp_tester | level2); // RULE_02 RULE_05
    assign pp_boot  = (pp_req.addr[15:12] == BOOT_PAGE);

    // Self-rewrite command decode from the command register.
    assign cmd_wr   = reg_we && reg_addr == REG_FCMD;
    assign cpu_boot = (faddr_q[15:12] == BOOT_PAGE);
    always_comb begin
        cpu_op  = OP_READ;
        cpu_bad = 1'b0;
        case (reg_wdata[7:0])
            CMD_READ_ARRAY: cpu_op = OP_READ; // RULE_20
            CMD_PROGRAM:    cpu_op = OP_PROGRAM;
            CMD_ERASE:      cpu_op = OP_ERASE;
            default:        cpu_bad = 1'b1;
        endcase
    end
    // The CPU path is closed in parallel mode, where the programmer owns
    // the array, and closed to boot writes in serial mode.
    assign cpu_ok = cmd_wr && !parallel && !cpu_bad
                  && !(serial && cpu_op != OP_READ && cpu_boot); // RULE_13 RULE_14

    // Flash request register, shared by both masters.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fl_req     <= '0;
            pp_refused <= 1'b0;
        end else begin
            fl_req.valid <= 1'b0;
            pp_refused   <= 1'b0;
            if (parallel && pp_req.valid) begin
                if (pp_block) begin
                    pp_refused <= 1'b1;
                end else begin
                    fl_req.valid <= 1'b1;
                    fl_req.op    <= pp_req.op;
                    fl_req.data  <= pp_req.data;
                    fl_req.addr  <= (pp_req.op == OP_ERASE && pp_boot)
                                  ? BOOT_BASE : pp_req.addr; // RULE_10
                end
            end else if (cpu_ok) begin
                fl_req.valid <= 1'b1;
                fl_req.op    <= cpu_op;
                fl_req.data  <= fdata_q;
                fl_req.addr  <= (cpu_op == OP_ERASE && cpu_boot) ? BOOT_BASE : faddr_q;
            end
        end
    end

    // Read return: array data are valid the cycle after a read request.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_pend_q <= 1'b0;
            rd_cpu_q  <= 1'b0;
            pp_done   <= 1'b0;
            pp_rdata  <= 8'h00;
        end else begin
            rd_pend_q <= fl_req.valid && fl_req.op == OP_READ;
            rd_cpu_q  <= !parallel;
            pp_done   <= rd_pend_q && !rd_cpu_q;
            if (rd_pend_q && !rd_cpu_q) begin
                pp_rdata <= fl_rdata;
            end
        end
    end

    // Software-owned control, address and data registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= 2'b00;
            faddr_q <= 16'h0000;
            fdata_q <= 8'h00;
        end else begin
            if (reg_we && reg_addr == REG_CTRL) begin
                ctrl_q <= reg_wdata[1:0];
            end
            if (reg_we && reg_addr == REG_FADDR) begin
                faddr_q <= reg_wdata;
            end
            if (rd_pend_q && rd_cpu_q) begin
                fdata_q <= fl_rdata; // Array read wins over a software write.
            end else if (reg_we && reg_addr == REG_FDATA) begin
                fdata_q <= reg_wdata[7:0];
            end
        end
    end

    // Sticky refusal flag, cleared by writing one to its status bit. A
    // refusal in the clearing cycle wins so that it is not lost.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if ((cmd_wr && !cpu_ok) || (serial && rx_valid && ser_q == SER_LOCKED)) begin
            refused_q <= 1'b1;
        end else if (reg_we && reg_addr == REG_STAT && reg_wdata[STAT_REFUSED]) begin
            refused_q <= 1'b0;
        end
    end

    fpe_shift u_shift (
        .core_clk (core_clk),
        .rst      (rst),
        .en       (serial),
        .variant  (ctrl_q[CTRL_VARIANT]),
        .sclk_s   (pins.sclk),
        .rxd_s    (pins.rxd),
        .tx_load  (reg_we && reg_addr == REG_TX),
        .tx_byte  (reg_wdata[7:0]),
        .rx_valid (rx_valid),
        .rx_byte  (rx_byte),
        .tx_busy  (tx_busy),
        .txd_o    (txd)
    ); // RULE_15

    // ID check. A blank array opens the link at once; otherwise
    // all seven bytes must match the stored code, and one
    // mismatch locks later commands out until reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ser_q    <= SER_ID;
            id_idx_q <= 3'h0;
            id_bad_q <= 1'b0;
        end else if (serial) begin
            case (ser_q)
                SER_ID: begin
                    if (array_blank) begin
                        ser_q <= SER_OPEN;
                    end else if (rx_valid) begin // RULE_07 RULE_08
                        id_idx_q <= id_idx_q + 3'h1;
                        if (id_idx_q == ID_LAST_IDX) begin
                            ser_q <= (id_bad_q || rx_byte != array_id[id_idx_q])
                                   ? SER_LOCKED : SER_OPEN;
                        end else if (rx_byte != array_id[id_idx_q]) begin
                            id_bad_q <= 1'b1;
                        end
                    end
                end
                SER_OPEN:   ser_q <= SER_OPEN;
                SER_LOCKED: ser_q <= SER_LOCKED;
                default:    ser_q <= SER_ID;
            endcase
        end
    end

    // Received command bytes go to the CPU only once the link is open.
    assign rx_pop = reg_re && reg_addr == REG_RX;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_hold_q <= 8'h00;
            rx_full_q <= 1'b0;
        end else if (serial && rx_valid && ser_q == SER_OPEN) begin
            rx_hold_q <= rx_byte; // RULE_07 RULE_14
            rx_full_q <= 1'b1;
        end else if (rx_pop) begin
            rx_full_q <= 1'b0;
        end
    end

    // Busy while a byte waits, software asks or a read is in flight;
    // it reads low outside serial mode,
    // so a normal board sees a quiet pin.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_pin <= 1'b0;
        end else begin
            busy_pin <= serial && (rx_full_q || ctrl_q[CTRL_BUSY] || rd_pend_q); // RULE_17
        end
    end

    // The transmit pin is an entry strap until serial mode takes it over.
    assign serial_transmit_pin_o  = txd;
    assign serial_transmit_pin_oe = serial;

    // Status word.
    always_comb begin
        stat_word               = 16'h0000;
        stat_word[1:0]          = mode_q;
        stat_word[STAT_PROT]    = prot_on;
        stat_word[STAT_LVL2]    = level2;
        stat_word[STAT_OPEN]    = (ser_q == SER_OPEN);
        stat_word[STAT_LOCK]    = (ser_q == SER_LOCKED);
        stat_word[STAT_RXFULL]  = rx_full_q;
        stat_word[STAT_REFUSED] = refused_q;
        stat_word[STAT_TXBUSY]  = tx_busy;
    end

    // Read data stand only in the cycle after the strobe; unmapped
    // and write-only indices read as zero.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_re) begin
            case (reg_addr)
                REG_CTRL:  reg_rdata <= {14'h0000, ctrl_q};
                REG_STAT:  reg_rdata <= stat_word;
                REG_RX:    reg_rdata <= {8'h00, rx_hold_q};
                REG_FADDR: reg_rdata <= faddr_q;
                REG_FDATA: reg_rdata <= {8'h00, fdata_q};
                default:   reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : fpe_top

// *** inc/fpe_pkg.sv ***
// How it works
// RULE_01: Any zero protect bit turns protection on.
// RULE_02: Level 2 also blocks factory tester reads.
// RULE_03: Both levels requested means level 2.
// RULE_04: Release bits 00 turn protection off.
// RULE_05: Parallel mode cannot change release bits. The code refuses such changes only while protection is on.
// RULE_06: Programmer rewrites whole block 0, not byte.
// RULE_07: Non-blank flash needs ID match for commands.
// RULE_08: Stored ID is seven bytes, FFD4 to FFDA.
// RULE_09: Programmer keeps boot operations inside F000-FFFF.
// RULE_10: Boot erase covers the whole 4K block.
// RULE_11: Programmer sets pins, then releases reset, for serial.
// RULE_12: Mode pin low during reset means normal.
// RULE_13: Serial mode refuses boot area writes.
// RULE_14: Own CPU handles serial data and rewrites.
// RULE_15: Serial has synchronous and asynchronous variants.
// RULE_16: Programmer drives the serial shift clock.
// RULE_17: Busy output is driven during serial programming.
// RULE_18: Programmer sets ports, mode pin, then reset.
// RULE_19: Mode pins are sampled once at reset release.
// RULE_20: Command byte FF returns to array reads.
package fpe_pkg;
    // Flash map.
    localparam logic [15:0] PROT_ADDR   = 16'hFFDB;
    localparam logic [15:0] ID_FIRST    = 16'hFFD4;
    localparam logic [15:0] ID_LAST     = 16'hFFDA;
    localparam logic [15:0] BOOT_BASE   = 16'hF000;
    localparam logic [3:0]  BOOT_PAGE   = 4'hF;
    localparam int          ID_BYTES    = 7;
    localparam logic [2:0]  ID_LAST_IDX = 3'h6;
    // Protect control byte fields.
    localparam int PROT_L1_BIT = 2;
    localparam int PROT_L2_BIT = 3;
    localparam int REL_LO_BIT  = 6;
    localparam int REL_HI_BIT  = 7;
    // Self-rewrite command bytes.
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_PROGRAM    = 8'h40;
    localparam logic [7:0] CMD_ERASE      = 8'h20;
    // Register indices.
    localparam logic [2:0] REG_CTRL  = 3'h0;
    localparam logic [2:0] REG_STAT  = 3'h1;
    localparam logic [2:0] REG_RX    = 3'h2;
    localparam logic [2:0] REG_TX    = 3'h3;
    localparam logic [2:0] REG_FADDR = 3'h4;
    localparam logic [2:0] REG_FDATA = 3'h5;
    localparam logic [2:0] REG_FCMD  = 3'h6;
    localparam int CTRL_VARIANT = 0;
    localparam int CTRL_BUSY    = 1;
    localparam int STAT_PROT    = 2;
    localparam int STAT_LVL2    = 3;
    localparam int STAT_OPEN    = 4;
    localparam int STAT_LOCK    = 5;
    localparam int STAT_RXFULL  = 6;
    localparam int STAT_REFUSED = 7;
    localparam int STAT_TXBUSY  = 8;
    // Serial timing.
    localparam int             CLK_HZ      = 40_000_000;
    localparam int             BAUD_HZ     = 115_200;
    localparam int             BAUD_CYC    = CLK_HZ / BAUD_HZ;
    localparam int             BAUD_W      = 9;
    localparam logic [8:0]     BAUD_RELOAD = 9'(BAUD_CYC - 1);
    localparam logic [8:0]     BAUD_HALF   = 9'(BAUD_CYC / 2);
    localparam logic [3:0]     DATA_BITS   = 4'h8;
    localparam logic [3:0]     FRAME_BITS  = 4'hA;
    localparam logic [3:0]     FRAME_LAST  = 4'h9;

    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_PARALLEL = 2'b01,
        MODE_SERIAL   = 2'b10
    } fpe_mode_e;

    typedef enum logic [1:0] {
        OP_READ    = 2'b00,
        OP_PROGRAM = 2'b01,
        OP_ERASE   = 2'b10
    } fpe_op_e;

    typedef enum logic [1:0] {
        SER_ID     = 2'b00,
        SER_OPEN   = 2'b01,
        SER_LOCKED = 2'b10
    } fpe_ser_e;

    typedef struct packed {
        logic        valid;
        fpe_op_e     op;
        logic [15:0] addr;
        logic [7:0]  data;
    } fpe_freq_s;

    typedef struct packed {
        logic mode_sel;
        logic rst_ctl;
        logic ce;
        logic sclk;
        logic txd;
        logic rxd;
    } fpe_pins_s;
endpackage : fpe_pkg

// *** src/fpe_shift.sv ***
`timescale 1ns/10ps
// Serial bit engine: programmer's shift clock in the synchronous
// variant, internal baud divider in the other.
module fpe_shift
    import fpe_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       en,
    input  wire logic       variant,
    input  wire logic       sclk_s,
    input  wire logic       rxd_s,
    input  wire logic       tx_load,
    input  wire logic [7:0] tx_byte,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_busy,
    output logic            txd_o
);
    logic              sclk_prev_q;
    logic              rise;
    logic              fall;
    logic [BAUD_W-1:0] rx_cnt_q;
    logic [BAUD_W-1:0] tx_cnt_q;
    logic [3:0]        rx_bits_q;
    logic [3:0]        tx_left_q;
    logic              rx_act_q;
    logic [7:0]        rx_sh_q;
    logic [9:0]        tx_sh_q;

    // Edge finder on the already synchronised shift clock.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end
    assign rise = sclk_s & ~sclk_prev_q;
    assign fall = ~sclk_s & sclk_prev_q;

    // Receiver, LSB first in both variants.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_valid  <= 1'b0;
            rx_byte   <= 8'h00;
            rx_act_q  <= 1'b0;
            rx_bits_q <= 4'h0;
            rx_cnt_q  <= '0;
            rx_sh_q   <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!en) begin
                rx_act_q  <= 1'b0;
                rx_bits_q <= 4'h0;
            end else if (!variant) begin // RULE_15 RULE_16
                if (rise) begin
                    rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
                    if (rx_bits_q == DATA_BITS - 4'h1) begin
                        rx_bits_q <= 4'h0;
                        rx_valid  <= 1'b1;
                        rx_byte   <= {rxd_s, rx_sh_q[7:1]};
                    end else begin
                        rx_bits_q <= rx_bits_q + 4'h1;
                    end
                end
            end else if (!rx_act_q) begin // RULE_15
                if (!rxd_s) begin
                    rx_act_q  <= 1'b1;
                    rx_cnt_q  <= BAUD_HALF;
                    rx_bits_q <= 4'h0;
                end
            end else if (rx_cnt_q != '0) begin
                rx_cnt_q <= rx_cnt_q - 9'h001;
            end else begin
                rx_cnt_q  <= BAUD_RELOAD;
                rx_bits_q <= rx_bits_q + 4'h1;
                if (rx_bits_q == 4'h0 && rxd_s) begin
                    rx_act_q <= 1'b0; // Glitch, not a start bit.
                end else if (rx_bits_q == FRAME_LAST) begin
                    rx_act_q <= 1'b0;
                    rx_valid <= rxd_s; // A bad stop bit drops the byte.
                    rx_byte  <= rx_sh_q;
                end else if (rx_bits_q != 4'h0) begin
                    rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
                end
            end
        end
    end

    // Transmitter; a load while busy is ignored.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_sh_q   <= 10'h3FF;
            tx_left_q <= 4'h0;
            tx_cnt_q  <= '0;
        end else if (!en) begin
            tx_sh_q   <= 10'h3FF;
            tx_left_q <= 4'h0;
        end else if (tx_load && tx_left_q == 4'h0) begin
            tx_sh_q   <= variant ? {1'b1, tx_byte, 1'b0} : {2'b11, tx_byte};
            tx_left_q <= variant ? FRAME_BITS : DATA_BITS;
            tx_cnt_q  <= BAUD_RELOAD;
        end else if (tx_left_q != 4'h0) begin
            if (variant && tx_cnt_q != '0) begin
                tx_cnt_q <= tx_cnt_q - 9'h001;
            end else if (variant || fall) begin
                tx_cnt_q  <= BAUD_RELOAD;
                tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                tx_left_q <= tx_left_q - 4'h1;
            end
        end
    end
    assign tx_busy = (tx_left_q != 4'h0);
    assign txd_o   = tx_sh_q[0];
endmodule : fpe_shift

// *** testbench/fpe_top_properties.sv ***
`timescale 1ns/10ps
// Checks on protection, boot area and mode entry.
module fpe_top_properties
    import fpe_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       serial_transmit_pin_o,
    input wire logic       serial_transmit_pin_oe,
    input wire logic       busy_pin,
    input wire fpe_freq_s  pp_req,
    input wire logic       pp_tester,
    input wire logic       pp_done,
    input wire logic       pp_refused,
    input wire fpe_freq_s  fl_req,
    input wire logic [7:0] array_prot_byte
);
    // Any protect bit zero, release pair not 00.
    logic prot_on;
    logic pp_hit;
    assign prot_on = !(array_prot_byte[PROT_L1_BIT] && array_prot_byte[PROT_L2_BIT]) &&
                     (array_prot_byte[REL_HI_BIT] || array_prot_byte[REL_LO_BIT]);
    assign pp_hit  = pp_req.valid && prot_on;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_prot_block: assert property (
        pp_hit && !pp_tester |=> !fl_req.valid) else $error("Read leaked.");
    a_level_two: assert property (
        pp_hit && !array_prot_byte[PROT_L2_BIT] |=> !fl_req.valid) else $error("Level 2 leak.");
    a_release_open: assert property (
        pp_req.valid && !array_prot_byte[REL_HI_BIT] && !array_prot_byte[REL_LO_BIT]
        |=> !pp_refused) else $error("Open refused.");
    a_no_modify: assert property (
        pp_hit && pp_req.op != OP_READ |=> !fl_req.valid) else $error("Change leaked.");
    a_read_timing: assert property (
        pp_done |-> $past(pp_req.valid, 3) && $past(pp_req.op, 3) == OP_READ)
        else $error("Late read.");
    a_boot_erase: assert property (
        fl_req.valid && fl_req.op == OP_ERASE && fl_req.addr[15:12] == BOOT_PAGE
        |-> fl_req.addr == BOOT_BASE) else $error("Boot erase partial.");
    a_serial_boot: assert property (
        serial_transmit_pin_oe && fl_req.valid && fl_req.op != OP_READ
        |-> fl_req.addr[15:12] != BOOT_PAGE) else $error("Boot written.");
    a_busy_idle: assert property (
        !serial_transmit_pin_oe |-> !busy_pin && serial_transmit_pin_o) else $error("Busy idle.");
    a_mode_fixed: assert property (
        !$past(rst) && !$past(rst, 2) |-> $stable(serial_transmit_pin_oe))
        else $error("Mode moved.");
endmodule : fpe_top_properties
bind fpe_top fpe_top_properties u_props (.*);

// *** testbench/fpe_prog_model.sv ***
`timescale 1ns/10ps
// Synchronous serial programmer; its clock idles low.
module fpe_prog_model (
    output logic sclk,
    output logic rxd
);
    // Entry straps.
    initial begin
        sclk = 1'b0;
        rxd  = 1'b1;
    end
    // LSB first; the 7 ns skew keeps edges off the core clock.
    task automatic send_byte(input logic [7:0] b);
        #7;
        for (int i = 0; i < 8; i++) begin
            rxd = b[i];
            #100;
            sclk = 1'b1;
            #100;
            sclk = 1'b0;
        end
        rxd = ~b[7]; // Released line shows the inverse.
    endtask : send_byte
endmodule : fpe_prog_model

// *** testbench/fpe_top_tb.sv ***
`timescale 1ns/10ps
module fpe_top_tb;
    import fpe_pkg::*;
    logic        core_clk, sclk, rxd, txo, txoe, busy, done, refd;
    logic        rst = 1'b1, msel = 1'b1, rctl = 1'b1, tester = 1'b0, we = 1'b0, re = 1'b0;
    logic [2:0]  ra = 3'h0;
    logic [15:0] wd = 16'h0000, rdat, v;
    logic [7:0]  prot = 8'hFF, prd;
    fpe_freq_s   preq = '0, freq;
    int          num_errors = 0, samples_checked = 0;
    fpe_top uut (.core_clk(core_clk), .rst(rst), .mode_select_pin(msel),
        .reset_control_input(rctl), .chip_enable_pin(1'b1), .serial_shift_clock_pin(sclk),
        .serial_receive_pin(rxd), .serial_transmit_pin_i(txoe ? txo : 1'b1),
        .serial_transmit_pin_o(txo), .serial_transmit_pin_oe(txoe), .busy_pin(busy),
        .pp_req(preq), .pp_tester(tester), .pp_rdata(prd), .pp_done(done), .pp_refused(refd),
        .reg_addr(ra), .reg_wdata(wd), .reg_we(we), .reg_re(re), .reg_rdata(rdat),
        .fl_req(freq), .fl_rdata(8'hA5), .array_prot_byte(prot),
        .array_id(56'h77665544332211), .array_blank(1'b0));
    fpe_prog_model prog (.sclk(sclk), .rxd(rxd));
    // Core clock at 40 MHz.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge core_clk);
        we <= 1'b0;
        #1; // A following write raises the strobe in a later step.
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        ra <= a;
        re <= 1'b1;
        @(posedge core_clk);
        re <= 1'b0;
        #1 d = rdat;
        @(posedge core_clk);
    endtask : rd
    // Straps held under reset, latched at release.
    task automatic boot(input logic m, input logic r);
        rst <= 1'b1;
        msel <= m;
        rctl <= r;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : boot
    task automatic ppc(input logic [7:0] p, input fpe_op_e op, input logic [15:0] a,
                       input logic t, input logic er, input logic [15:0] ea);
        logic e;
        e = (op == OP_READ) && !er;
        prot <= p;
        @(posedge core_clk);
        preq <= '{1'b1, op, a, 8'h3C};
        tester <= t;
        @(posedge core_clk);
        preq <= '0;
        #1 chk({refd, freq.valid, er ? 16'h0 : freq.addr}, {er, !er, ea});
        repeat (2) @(posedge core_clk);
        #1 chk({done, done ? prd : 8'h00}, {e, e ? 8'hA5 : 8'h00});
        @(posedge core_clk);
    endtask : ppc
    task automatic t_parallel;
        boot(1'b1, 1'b1);
        ppc(8'hFF, OP_READ, 16'h1234, 1'b0, 1'b0, 16'h1234);
        ppc(8'hFB, OP_READ, 16'h1234, 1'b0, 1'b1, 16'h0000);
        ppc(8'hFB, OP_READ, 16'h0042, 1'b1, 1'b0, 16'h0042);
        ppc(8'hF3, OP_READ, 16'h0042, 1'b1, 1'b1, 16'h0000);
        ppc(8'hFB, OP_PROGRAM, 16'h0042, 1'b1, 1'b1, 16'h0000);
        ppc(8'h3B, OP_READ, 16'h0077, 1'b0, 1'b0, 16'h0077);
        ppc(8'hFF, OP_ERASE, 16'hF123, 1'b0, 1'b0, 16'hF000);
    endtask : t_parallel
    // Seven ID bytes; only the first varies.
    task automatic send_id(input logic [7:0] first);
        prog.send_byte(first);
        for (int i = 1; i < ID_BYTES; i++)
            prog.send_byte(8'(8'h11 * (i + 1)));
        repeat (8) @(posedge core_clk);
    endtask : send_id
    task automatic t_serial;
        boot(1'b1, 1'b0);
        rd(REG_STAT, v);
        chk({v[1:0], txoe}, {MODE_SERIAL, 1'b1});
        send_id(8'h00);
        rd(REG_STAT, v);
        chk(v[5:4], 2'h2);
        boot(1'b1, 1'b0);
        send_id(8'h11);
        rd(REG_STAT, v);
        chk(v[5:4], 2'h1);
        prog.send_byte(8'hC3);
        for (int i = 0; i < 60 && busy !== 1'b1; i++)
            @(posedge core_clk);
        chk(busy, 1'b1);
        rd(REG_RX, v);
        chk(v, 16'h00C3);
        wr(REG_FADDR, 16'hF010);
        wr(REG_FCMD, 16'h0040);
        rd(REG_STAT, v);
        chk(v[STAT_REFUSED], 1'b1);
        wr(REG_FADDR, 16'h0123);
        wr(REG_FCMD, 16'h0040);
        wr(REG_FCMD, 16'h00FF);
        #1 chk({freq.valid, freq.op, freq.addr[11:0]}, {1'b1, OP_READ, 12'h123});
        @(posedge core_clk);
    endtask : t_serial
    task automatic t_normal;
        boot(1'b0, 1'b1);
        rd(REG_STAT, v);
        chk({v[1:0], txoe, busy}, {MODE_NORMAL, 2'b00});
        rd(3'h7, v);
        chk(v, 16'h0000);
    endtask : t_normal
    task automatic print_verdict;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // Main sequence.
    initial begin
        t_parallel();
        t_serial();
        t_normal();
        print_verdict();
    end
    // Watchdog; a run needs under 4000 cycles.
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
endmodule : fpe_top_tb
